// file: include/nsw_defs.vh
// constants for the nibble exchange execution block
// Contract
// - result takes operand nibbles in swapped order
// - destination bit 0 to working, 1 to file
// - bank bit 0 access bank, 1 bank select
// - extended set, a=0, f<=95 uses indexed offset
`ifndef NSW_DEFS_VH
`define NSW_DEFS_VH

// ***************************************************
// register byte offsets on the axi4-lite bus
// ***************************************************
`define NSW_OFS_CTRL        8'h00
`define NSW_OFS_INSTR       8'h04
`define NSW_OFS_BANK_SEL    8'h08
`define NSW_OFS_INDEX_BASE  8'h0C
`define NSW_OFS_WORK        8'h10
`define NSW_OFS_STATUS      8'h14
`define NSW_OFS_MEM_ADDR    8'h18
`define NSW_OFS_MEM_DATA    8'h1C
`define NSW_OFS_EFF_ADDR    8'h20

// ***************************************************
// field positions
// ***************************************************
`define NSW_CTRL_GO_BIT     0
`define NSW_CTRL_EXT_BIT    1
`define NSW_STAT_BUSY_BIT   0
`define NSW_STAT_DONE_BIT   1
`define NSW_STAT_BAD_BIT    2
`define NSW_INSTR_D_BIT     9
`define NSW_INSTR_A_BIT     8

// ***************************************************
// encodings and reset values
// ***************************************************
`define NSW_OPCODE          6'h0E
`define NSW_INDEXED_MAX     8'h5F
`define NSW_SFR_BANK        4'hF
`define NSW_ACCESS_LOW_BANK 4'h0
`define NSW_RST_INSTR       16'h0000
`define NSW_RESP_OKAY       2'h0
`define NSW_RESP_SLVERR     2'h2

`endif

// file: src/nsw_operand_path.v
// operand address resolution and nibble exchange datapath
`timescale 1ns/10ps
`include "nsw_defs.vh"

module nsw_operand_path (
    file_addr,
    bank_bit,
    ext_en,
    bank_sel,
    index_base,
    operand,
    eff_addr,
    swapped
);
    input  wire [7:0]  file_addr;   // 8-bit f field
    input  wire        bank_bit;    // a field
    input  wire        ext_en;      // extended instruction set on
    input  wire [3:0]  bank_sel;    // bank select register
    input  wire [11:0] index_base;  // base pointer for indexed offset
    input  wire [7:0]  operand;     // byte read from the file
    output reg  [11:0] eff_addr;    // resolved 12-bit data address
    output wire [7:0]  swapped;     // exchanged byte

    // ***************************************************
    // nibble exchange
    // ***************************************************
    assign swapped = {operand[3:0], operand[7:4]};

    // ***************************************************
    // address resolution
    // ***************************************************
    // indexed offset wraps in 12 bits, like the base pointer itself
    always @* begin
        eff_addr = 12'h000;
        if (bank_bit) begin
            eff_addr = {bank_sel, file_addr};
        end else if (ext_en && (file_addr <= `NSW_INDEXED_MAX)) begin
            eff_addr = index_base + {4'h0, file_addr};
        end else if (file_addr <= `NSW_INDEXED_MAX) begin
            // low part of the access bank sits in bank 0
            eff_addr = {`NSW_ACCESS_LOW_BANK, file_addr};
        end else begin
            // high part of the access bank maps to special registers
            eff_addr = {`NSW_SFR_BANK, file_addr};
        end
    end
endmodule

// file: src/nsw_top.v
// nibble exchange execution core with axi4-lite register slave
`timescale 1ns/10ps
`include "nsw_defs.vh"

module nsw_top #(
    parameter ADDR_W = 12  // data memory address width
) (
    clk,
    reset_n,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
    input  wire        clk;
    input  wire        reset_n;
    input  wire [7:0]  s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output wire [1:0]  s_axi_bresp;
    output wire        s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [7:0]  s_axi_araddr;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output wire [31:0] s_axi_rdata;
    output wire [1:0]  s_axi_rresp;
    output wire        s_axi_rvalid;
    input  wire        s_axi_rready;

    // ***************************************************
    // quarter phase states, one-hot
    // ***************************************************
    localparam ST_IDLE = 5'b00001;
    localparam ST_Q1   = 5'b00010;  // decode
    localparam ST_Q2   = 5'b00100;  // read file register
    localparam ST_Q3   = 5'b01000;  // process data
    localparam ST_Q4   = 5'b10000;  // write destination

    // ***************************************************
    // reset synchroniser
    // ***************************************************
    reg rst_meta_ff;  // first stage, read only by second
    reg rst_n_ff;     // released reset used everywhere

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ***************************************************
    // state declarations
    // ***************************************************
    reg [7:0]        data_mem [0:(1<<ADDR_W)-1]; // file register space
    reg              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    reg [1:0]        bresp_ff, rresp_ff;
    reg [31:0]       rdata_ff;
    reg              aw_full_ff, w_full_ff;      // captured write halves
    reg [7:0]        awaddr_ff;
    reg [31:0]       wdata_ff;
    reg [3:0]        wstrb_ff;
    reg [15:0]       instr_ff;                   // instruction word
    reg              ext_en_ff;                  // extended set enable
    reg [3:0]        bank_sel_ff;                // bank_select_register
    reg [11:0]       index_base_ff;
    reg [7:0]        work_ff;                    // working register
    reg              done_ff, bad_ff;
    reg [ADDR_W-1:0] mem_addr_ff;
    reg [4:0]        state_ff;
    reg [11:0]       eff_addr_ff;
    reg [7:0]        operand_ff, result_ff;
    reg              dest_ff, legal_ff;

    wire [11:0] eff_addr;
    wire [7:0]  swapped;

    // datapath shared with the address resolver
    nsw_operand_path u_path (
        .file_addr  (instr_ff[7:0]),
        .bank_bit   (instr_ff[`NSW_INSTR_A_BIT]),
        .ext_en     (ext_en_ff),
        .bank_sel   (bank_sel_ff),
        .index_base (index_base_ff),
        .operand    (operand_ff),
        .eff_addr   (eff_addr),
        .swapped    (swapped)
    );

    // ***************************************************
    // bus decode helpers
    // ***************************************************
    wire aw_hs   = s_axi_awvalid & awready_ff;
    wire w_hs    = s_axi_wvalid & wready_ff;
    wire ar_hs   = s_axi_arvalid & arready_ff;
    wire do_wr   = aw_full_ff & w_full_ff & ~bvalid_ff;
    wire busy    = ~state_ff[0];
    wire wr_ctrl = do_wr & (awaddr_ff == `NSW_OFS_CTRL) & wstrb_ff[0];
    wire go      = wr_ctrl & wdata_ff[`NSW_CTRL_GO_BIT] & ~busy;
    wire wr_stat = do_wr & (awaddr_ff == `NSW_OFS_STATUS) & wstrb_ff[0];
    wire q4_file = state_ff[4] & legal_ff & dest_ff;
    wire q4_work = state_ff[4] & legal_ff & ~dest_ff;

    // write address known to the map
    reg wr_hit;
    always @* begin
        case (awaddr_ff)
            `NSW_OFS_CTRL, `NSW_OFS_INSTR, `NSW_OFS_BANK_SEL, `NSW_OFS_INDEX_BASE,
            `NSW_OFS_WORK, `NSW_OFS_STATUS, `NSW_OFS_MEM_ADDR, `NSW_OFS_MEM_DATA,
            `NSW_OFS_EFF_ADDR: wr_hit = 1'b1;
            default:           wr_hit = 1'b0;
        endcase
    end

    // read mux, unmapped words answer slverr
    reg [31:0] rd_val;
    reg        rd_hit;
    always @* begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `NSW_OFS_CTRL:       rd_val = {30'h0, ext_en_ff, 1'b0};
            `NSW_OFS_INSTR:      rd_val = {16'h0000, instr_ff};
            `NSW_OFS_BANK_SEL:   rd_val = {28'h0, bank_sel_ff};
            `NSW_OFS_INDEX_BASE: rd_val = {20'h0, index_base_ff};
            `NSW_OFS_WORK:       rd_val = {24'h0, work_ff};
            `NSW_OFS_STATUS:     rd_val = {29'h0, bad_ff, done_ff, busy};
            `NSW_OFS_MEM_ADDR:   rd_val = {{(32-ADDR_W){1'b0}}, mem_addr_ff};
            `NSW_OFS_MEM_DATA:   rd_val = {24'h0, data_mem[mem_addr_ff]};
            `NSW_OFS_EFF_ADDR:   rd_val = {20'h0, eff_addr_ff};
            default:             rd_hit = 1'b0;
        endcase
    end

    // ***************************************************
    // axi4-lite channel handshakes
    // ***************************************************
    // halves are taken in either order; the slave holds off new ones
    // until the response has been accepted
    always @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `NSW_RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `NSW_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            aw_full_ff <= (aw_full_ff | aw_hs) & ~do_wr;
            w_full_ff  <= (w_full_ff | w_hs) & ~do_wr;
            awready_ff <= ~(aw_full_ff | aw_hs) & ~(bvalid_ff | do_wr);
            wready_ff  <= ~(w_full_ff | w_hs) & ~(bvalid_ff | do_wr);
            if (do_wr) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_hit ? `NSW_RESP_OKAY : `NSW_RESP_SLVERR;
            end else if (bvalid_ff & s_axi_bready) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= ~aw_full_ff;
                wready_ff  <= ~w_full_ff;
            end
            if (ar_hs) begin
                rvalid_ff  <= 1'b1;
                arready_ff <= 1'b0;
                rdata_ff   <= rd_val;
                rresp_ff   <= rd_hit ? `NSW_RESP_OKAY : `NSW_RESP_SLVERR;
            end else if (rvalid_ff & s_axi_rready) begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end else if (!rvalid_ff) begin
                arready_ff <= 1'b1;
            end
        end
    end

    // ***************************************************
    // software registers and status flags
    // ***************************************************
    always @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            instr_ff      <= `NSW_RST_INSTR;
            ext_en_ff     <= 1'b0;
            bank_sel_ff   <= 4'h0;
            index_base_ff <= 12'h000;
            work_ff       <= 8'h00;
            mem_addr_ff   <= {ADDR_W{1'b0}};
            done_ff       <= 1'b0;
            bad_ff        <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ext_en_ff <= wdata_ff[`NSW_CTRL_EXT_BIT];
            end
            // configuration other than the extended set enable is frozen while an instruction runs
            if (do_wr & ~busy & wstrb_ff[0]) begin
                case (awaddr_ff)
                    `NSW_OFS_INSTR:      instr_ff[7:0]       <= wdata_ff[7:0];
                    `NSW_OFS_BANK_SEL:   bank_sel_ff         <= wdata_ff[3:0];
                    `NSW_OFS_INDEX_BASE: index_base_ff[7:0]  <= wdata_ff[7:0];
                    `NSW_OFS_MEM_ADDR:   mem_addr_ff         <= wdata_ff[ADDR_W-1:0];
                    default:             instr_ff[7:0]       <= instr_ff[7:0];
                endcase
            end
            if (do_wr & ~busy & wstrb_ff[1]) begin
                if (awaddr_ff == `NSW_OFS_INSTR) begin
                    instr_ff[15:8] <= wdata_ff[15:8];
                end
                if (awaddr_ff == `NSW_OFS_INDEX_BASE) begin
                    index_base_ff[11:8] <= wdata_ff[11:8];
                end
            end
            // a result landing in the working register beats a bus write
            if (q4_work) begin
                work_ff <= result_ff;
            end else if (do_wr & ~busy & wstrb_ff[0] & (awaddr_ff == `NSW_OFS_WORK)) begin
                work_ff <= wdata_ff[7:0];
            end
            // write-one-to-clear; a completion in the same cycle wins
            if (state_ff[4]) begin
                done_ff <= 1'b1;
            end else if (wr_stat & wdata_ff[`NSW_STAT_DONE_BIT]) begin
                done_ff <= 1'b0;
            end
            if (state_ff[1] & (instr_ff[15:10] != `NSW_OPCODE)) begin
                bad_ff <= 1'b1;
            end else if (wr_stat & wdata_ff[`NSW_STAT_BAD_BIT]) begin
                bad_ff <= 1'b0;
            end
        end
    end

    // ***************************************************
    // file register memory
    // ***************************************************
    // software writes are dropped while busy so q4 never collides
    always @(posedge clk) begin
        if (q4_file) begin
            data_mem[eff_addr_ff[ADDR_W-1:0]] <= result_ff;
        end else if (do_wr & ~busy & wstrb_ff[0] & (awaddr_ff == `NSW_OFS_MEM_DATA)) begin
            data_mem[mem_addr_ff] <= wdata_ff[7:0];
        end
    end

    // ***************************************************
    // quarter phase sequencer
    // ***************************************************
    // one instruction cycle of four quarters; bad is set in q1 and done in q4, outside this block
    always @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff    <= ST_IDLE;
            eff_addr_ff <= 12'h000;
            operand_ff  <= 8'h00;
            result_ff   <= 8'h00;
            dest_ff     <= 1'b1;
            legal_ff    <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (go) begin
                        state_ff <= ST_Q1;
                    end
                end
                ST_Q1: begin
                    legal_ff    <= (instr_ff[15:10] == `NSW_OPCODE);
                    dest_ff     <= instr_ff[`NSW_INSTR_D_BIT];
                    eff_addr_ff <= eff_addr;
                    state_ff    <= ST_Q2;
                end
                ST_Q2: begin
                    operand_ff <= data_mem[eff_addr_ff[ADDR_W-1:0]];
                    state_ff   <= ST_Q3;
                end
                ST_Q3: begin
                    result_ff <= swapped;
                    state_ff  <= ST_Q4;
                end
                ST_Q4: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ***************************************************
    // outputs straight from flops
    // ***************************************************
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
endmodule

// file: tb/nsw_properties.sv
// bus timing checker for the nibble exchange core, bound to its top
`timescale 1ns/10ps

module nsw_properties (
    input wire        clk,
    input wire        reset_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    // ***************************************************
    // properties, all in the one clock domain
    // ***************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // both halves taken together: one idle cycle, then the answer
    property p_b_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("write answer held");
    property p_aw_once;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_once: assert property (p_aw_once) else $error("second address taken");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write open during answer");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_drop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_drop: assert property (p_r_drop) else $error("read answer held");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read open during answer");
    // only okay and slave error codes are ever produced
    property p_resp;
        (s_axi_bvalid |-> s_axi_bresp[0] == 1'b0) and (s_axi_rvalid |-> s_axi_rresp[0] == 1'b0);
    endproperty
    a_resp: assert property (p_resp) else $error("bad response code");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20 |=> s_axi_rresp == 2'h2;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read okay");
endmodule

bind nsw_top nsw_properties u_props (.clk(clk), .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: tb/nsw_testbench.sv
// self-checking bench for the nibble exchange core
`timescale 1ns/10ps
`include "nsw_defs.vh"

module testbench;
    reg         clk = 0, reset_n = 0;
    reg  [7:0]  awaddr = 0, araddr = 0;
    reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg  [31:0] wdata = 0;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    reg  [31:0] rd;         // last read word
    reg  [1:0]  rr, br;     // last read and write responses
    int         mismatches = 0, total_checks = 0;

    nsw_top dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial begin
        forever #50 clk = ~clk;
    end

    task results;
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ***************************************************
    // bus tasks: outputs are registered, so values seen
    // right after the edge are the sampled ones
    // ***************************************************
    task axi_wr(input [7:0] a, input [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 0;
            if (wvalid && wready === 1'b1) wvalid <= 0;
        end while (bvalid !== 1'b1 && n < 200);
        if (n >= 200) mismatches++;
        br = bresp;
        bready <= 0;
    endtask

    task axi_rd(input [7:0] a);
        int n;
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 0;
        end while (rvalid !== 1'b1 && n < 200);
        if (n >= 200) mismatches++;
        rd = rdata; rr = rresp;
        rready <= 0;
    endtask

    // ***************************************************
    // one instruction run; every expectation but the effective address derived here
    // ***************************************************
    task run_op(input [15:0] ins, input ext, input [3:0] bank, input [11:0] base,
                input [11:0] ea, input [7:0] val);
        reg legal;
        reg [7:0] sw;
        int n;
        legal = (ins[15:10] === 6'b001110);
        sw = {val[3:0], val[7:4]};
        axi_wr(`NSW_OFS_BANK_SEL, {28'h0, bank});
        axi_wr(`NSW_OFS_INDEX_BASE, {20'h0, base});
        axi_wr(`NSW_OFS_WORK, 32'hA5);
        axi_wr(`NSW_OFS_MEM_ADDR, {20'h0, ea});
        axi_wr(`NSW_OFS_MEM_DATA, {24'h0, val});
        axi_wr(`NSW_OFS_INSTR, {16'h0, ins});
        axi_wr(`NSW_OFS_CTRL, {30'h0, ext, 1'b1});
        n = 0;
        do begin
            axi_rd(`NSW_OFS_STATUS);
            n++;
        end while (rd[1] !== 1'b1 && n < 50);
        chk("status", {29'h0, !legal, 2'b10}, rd);
        // go reads back as zero, the extended set enable stays as written
        axi_rd(`NSW_OFS_CTRL);
        chk("ctrl", {30'h0, ext, 1'b0}, rd);
        if (legal) begin
            axi_rd(`NSW_OFS_EFF_ADDR);
            chk("eff_addr", {20'h0, ea}, rd);
        end
        axi_rd(`NSW_OFS_WORK);
        chk("work", (legal && !ins[9]) ? sw : 32'hA5, rd);
        axi_rd(`NSW_OFS_MEM_DATA);
        chk("mem", (legal && ins[9]) ? sw : val, rd);
        axi_wr(`NSW_OFS_STATUS, 32'h6);
    endtask

    // ***************************************************
    // scenarios
    // ***************************************************
    task t_map;
        axi_rd(`NSW_OFS_STATUS);
        chk("status_reset", 32'h0, rd);
        axi_rd(8'h40);
        chk("rd_unmapped", 2'h2, rr);
        axi_wr(8'h44, 32'h1);
        chk("wr_unmapped", 2'h2, br);
    endtask
    task t_bank_to_work;
        run_op(16'h3921, 0, 4'h3, 12'h000, 12'h321, 8'h53);
    endtask
    task t_bank_to_file;
        run_op(16'h3BFF, 0, 4'hA, 12'h000, 12'hAFF, 8'hC7);
    endtask
    task t_access_high;
        run_op(16'h3A60, 1, 4'h5, 12'h800, 12'hF60, 8'h1E);
    endtask
    task t_access_low;
        run_op(16'h385F, 0, 4'h5, 12'h800, 12'h05F, 8'h9B);
    endtask
    task t_indexed_wrap;
        run_op(16'h3A5F, 1, 4'h5, 12'hFE0, 12'h03F, 8'h6D);
    endtask
    task t_bad_opcode;
        run_op(16'h3E10, 0, 4'h0, 12'h000, 12'h010, 8'h42);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1;
        repeat (4) @(posedge clk);
        t_map;
        t_bank_to_work;
        t_bank_to_file;
        t_access_high;
        t_access_low;
        t_indexed_wrap;
        t_bad_opcode;
        results;
    end

    // watchdog: the run needs well under 5000 cycles
    initial begin
        #2000000;
        mismatches++;
        results;
    end
endmodule
